//--- core/sls_core.sv
`include "sls_defs.svh"

module sls_core #(
  parameter int MAIN_W = 13,
  parameter int FB_W   = 19
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic             sclk,
  input  wire logic             sdata,
  input  wire logic             latch_strobe,
  input  wire logic             chip_enable_pin,
  input  wire logic             ref_pin,
  input  wire logic             vco_pin,
  input  wire logic             pfd_sample,
  input  wire logic             phase_err_below_set,
  input  wire logic             phase_err_above_lose,
  output sls_pkg::sls_ctrl_s    ctrl_word,
  output sls_pkg::sls_fbk_s     fbk_word,
  output sls_pkg::sls_ref_s     ref_word,
  output logic                  gain_select,
  output logic [2:0]            pump_current,
  output logic                  pump_tristate_out,
  output logic                  rf_out_enable,
  output logic                  ref_buffer_enable,
  output logic                  output_halved,
  output logic                  ref_tick,
  output logic                  fb_tick,
  output logic                  band_clk_tick,
  output logic                  lock_detect,
  output logic                  power_down_out
);

  // Prescaler modulus decode.
  function automatic logic [5:0] sls_presc(input logic [1:0] sel);
    case (sel)
      2'h0:    sls_presc = `SLS_PRESC_8;
      2'h1:    sls_presc = `SLS_PRESC_16;
      default: sls_presc = `SLS_PRESC_32;
    endcase
  endfunction

  // Total feedback division, P times main count plus swallow count.
  function automatic logic [FB_W-1:0] sls_n_total(input logic [1:0] sel,
                                                   input logic [MAIN_W-1:0] b,
                                                   input logic [4:0] a);
    sls_n_total = FB_W'(sls_presc(sel) * b) + FB_W'(a);
  endfunction

  logic [`SLS_PIN_W-1:0]  pin_level;
  logic [`SLS_PIN_W-1:0]  pin_rise;
  logic [`SLS_WORD_W-1:0] shift_reg;
  sls_pkg::sls_pd_e       pd_state;
  sls_pkg::sls_pd_e       next_pd_state;
  logic [13:0]            ref_cnt;
  logic [FB_W-1:0]        fb_cnt;
  logic [2:0]             band_cnt;
  logic                   half_phase;
  logic [2:0]             good_cnt;

  // Pins from outside pass the three-stage synchroniser.
  sls_pin_sync #(
    .W (`SLS_PIN_W)
  ) u_pin_sync (
    .clk    (clk),
    .rst_b  (rst_b),
    .ce     (ce),
    .pin_in ({vco_pin, ref_pin, chip_enable_pin, latch_strobe, sdata, sclk}),
    .level  (pin_level),
    .rise   (pin_rise)
  );

  // Decoded strobes and selections.
  wire       sclk_rise   = pin_rise[`SLS_PIN_SCLK];
  wire       data_bit    = pin_level[`SLS_PIN_SDATA];
  wire       strobe_rise = pin_rise[`SLS_PIN_STROBE];
  wire       chip_on     = pin_level[`SLS_PIN_CE];
  wire       ref_edge    = pin_rise[`SLS_PIN_REF];
  wire       vco_edge    = pin_rise[`SLS_PIN_VCO];
  wire [1:0] word_sel    = shift_reg[1:0];
  wire       load_ctrl   = strobe_rise && (word_sel == `SLS_SEL_CTRL);
  wire       load_fbk    = strobe_rise && (word_sel == `SLS_SEL_FBK);
  wire       load_ref    = strobe_rise && (word_sel == `SLS_SEL_REF);
  wire sls_pkg::sls_ctrl_s new_ctrl = sls_pkg::sls_ctrl_s'(shift_reg);
  wire sls_pkg::sls_fbk_s  new_fbk  = sls_pkg::sls_fbk_s'(shift_reg);

  // Power-down condition and counter hold.
  wire powered_down  = !chip_on || (pd_state == sls_pkg::SLS_PD_DOWN);
  wire counters_held = powered_down || ctrl_word.counter_clear;

  // Serial input register, live in every power state.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shift_reg <= '0;
    end else if (ce && sclk_rise) begin
      shift_reg <= {shift_reg[`SLS_WORD_W-2:0], data_bit};
    end
  end

  // Latches load from the shift register on the strobe rise; test words are dropped.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_word <= sls_pkg::sls_ctrl_s'(`SLS_CTRL_RESET);
      fbk_word  <= sls_pkg::sls_fbk_s'(`SLS_FBK_RESET);
      ref_word  <= sls_pkg::sls_ref_s'(`SLS_REF_RESET);
    end else if (ce) begin
      if (load_ctrl) begin
        ctrl_word <= new_ctrl;
      end
      if (load_fbk) begin
        fbk_word <= new_fbk;
      end
      if (load_ref) begin
        ref_word <= sls_pkg::sls_ref_s'(shift_reg);
      end
    end
  end

  // Shared gain bit follows the most recent write through either latch.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gain_select <= 1'b0;
    end else if (ce) begin
      if (load_ctrl) begin
        gain_select <= new_ctrl.pump_gain_select;
      end else if (load_fbk) begin
        gain_select <= new_fbk.pump_gain_select;
      end
    end
  end

  // Power-down sequencer; a new control word decides the mode each time.
  always_comb begin
    next_pd_state = pd_state;
    if (load_ctrl) begin
      if (!new_ctrl.power_down_arm) begin
        next_pd_state = sls_pkg::SLS_PD_RUN;
      end else if (!new_ctrl.power_down_mode) begin
        next_pd_state = sls_pkg::SLS_PD_DOWN;
      end else if (pd_state != sls_pkg::SLS_PD_DOWN) begin
        next_pd_state = sls_pkg::SLS_PD_WAIT_ONE;
      end
    end else begin
      case (pd_state)
        sls_pkg::SLS_PD_RUN: begin
          next_pd_state = pd_state;
        end
        sls_pkg::SLS_PD_WAIT_ONE: begin
          if (ref_tick) begin
            next_pd_state = sls_pkg::SLS_PD_WAIT_TWO;
          end
        end
        sls_pkg::SLS_PD_WAIT_TWO: begin
          if (ref_tick) begin
            next_pd_state = sls_pkg::SLS_PD_DOWN;
          end
        end
        sls_pkg::SLS_PD_DOWN: begin
          next_pd_state = pd_state;
        end
        default: begin
          next_pd_state = sls_pkg::SLS_PD_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pd_state <= sls_pkg::SLS_PD_RUN;
    end else if (ce) begin
      pd_state <= next_pd_state;
    end
  end

  // Reference counter; a programmed zero behaves as division by one.
  wire ref_wrap = ({1'b0, ref_cnt} + 15'h0001) >= {1'b0, ref_word.ref_divide_count};
  wire next_ref_tick = !counters_held && ref_edge && ref_wrap;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ref_cnt  <= '0;
      ref_tick <= 1'b0;
    end else if (ce) begin
      ref_tick <= next_ref_tick;
      if (counters_held) begin
        ref_cnt <= '0;
      end else if (ref_edge) begin
        ref_cnt <= ref_wrap ? 14'h0000 : ref_cnt + 14'h0001;
      end
    end
  end

  // Output halving stage and feedback counter input selection.
  wire fb_edge = fbk_word.half_rate_feedback ? (vco_edge && half_phase) : vco_edge;
  wire [FB_W-1:0] n_total = sls_n_total(ctrl_word.prescaler_select,
                                        fbk_word.main_count, fbk_word.swallow_count);
  wire fb_wrap = (fb_cnt + FB_W'(1)) >= n_total;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      half_phase <= 1'b0;
      fb_cnt     <= '0;
      fb_tick    <= 1'b0;
    end else if (ce) begin
      half_phase <= powered_down ? 1'b0 : half_phase ^ vco_edge;
      fb_tick    <= !counters_held && fb_edge && fb_wrap;
      if (counters_held) begin
        fb_cnt <= '0;
      end else if (fb_edge) begin
        fb_cnt <= fb_wrap ? '0 : fb_cnt + FB_W'(1);
      end
    end
  end

  // Band-select clock divider on the reference output.
  wire [2:0] band_mask = (3'h1 << ref_word.band_clock_div) - 3'h1;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      band_cnt      <= '0;
      band_clk_tick <= 1'b0;
    end else if (ce) begin
      band_clk_tick <= ref_tick && ((band_cnt & band_mask) == band_mask);
      if (counters_held) begin
        band_cnt <= '0;
      end else if (ref_tick) begin
        band_cnt <= band_cnt + 3'h1;
      end
    end
  end

  // Digital lock detect: count good cycles, drop on a large error or on power-down.
  wire [2:0] lock_need = ref_word.lock_precision ? `SLS_LOCK_FINE : `SLS_LOCK_COARSE;
  wire [2:0] next_good = phase_err_below_set ? good_cnt + 3'h1 : 3'h0;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      good_cnt    <= '0;
      lock_detect <= 1'b0;
    end else if (ce) begin
      if (powered_down) begin
        good_cnt    <= '0;
        lock_detect <= 1'b0;
      end else if (pfd_sample) begin
        good_cnt <= (next_good >= lock_need) ? lock_need : next_good;
        if (phase_err_above_lose) begin
          lock_detect <= 1'b0;
        end else if (next_good >= lock_need) begin
          lock_detect <= 1'b1;
        end
      end
    end
  end

  // Registered analog-facing controls.
  wire [2:0] sel_current = gain_select ? ctrl_word.pump_current_set_two
                                       : ctrl_word.pump_current_set_one;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pump_current      <= '0;
      pump_tristate_out <= 1'b1;
      rf_out_enable     <= 1'b0;
      ref_buffer_enable <= 1'b0;
      output_halved     <= 1'b0;
      power_down_out    <= 1'b1;
    end else if (ce) begin
      pump_current      <= sel_current;
      pump_tristate_out <= powered_down || ctrl_word.pump_tristate;
      rf_out_enable     <= !powered_down && (!ctrl_word.mute_until_locked || lock_detect);
      ref_buffer_enable <= !powered_down;
      output_halved     <= fbk_word.half_rate_output;
      power_down_out    <= powered_down;
    end
  end

  // Checks on the latch, power and lock behaviour.
  property p_ctrl_load;
    @(posedge clk) disable iff (!rst_b)
    (ce && load_ctrl) |=> (ctrl_word == $past(new_ctrl));
  endproperty
  a_ctrl_load: assert property (p_ctrl_load) else $error("control latch not loaded");

  property p_fbk_load;
    @(posedge clk) disable iff (!rst_b)
    (ce && load_fbk) |=> (fbk_word == $past(new_fbk)) && (gain_select == $past(new_fbk.pump_gain_select));
  endproperty
  a_fbk_load: assert property (p_fbk_load) else $error("feedback latch not loaded");

  property p_ref_load;
    @(posedge clk) disable iff (!rst_b)
    (ce && load_ref) |=> (ref_word == $past(shift_reg)) && $stable(ctrl_word);
  endproperty
  a_ref_load: assert property (p_ref_load) else $error("reference latch not loaded");

  property p_async_pd;
    @(posedge clk) disable iff (!rst_b)
    (ce && load_ctrl && new_ctrl.power_down_arm && !new_ctrl.power_down_mode)
      |=> (pd_state == sls_pkg::SLS_PD_DOWN);
  endproperty
  a_async_pd: assert property (p_async_pd) else $error("asynchronous power-down late");

  property p_sync_pd;
    @(posedge clk) disable iff (!rst_b)
    (ce && pd_state == sls_pkg::SLS_PD_WAIT_TWO && ref_tick && !load_ctrl)
      |=> (pd_state == sls_pkg::SLS_PD_DOWN);
  endproperty
  a_sync_pd: assert property (p_sync_pd) else $error("synchronous power-down missed");

  property p_ce_pin;
    @(posedge clk) disable iff (!rst_b)
    (ce && !chip_on) |=> (!rf_out_enable && !ref_buffer_enable && pump_tristate_out);
  endproperty
  a_ce_pin: assert property (p_ce_pin) else $error("chip enable low did not disable");

  property p_pd_lock;
    @(posedge clk) disable iff (!rst_b)
    (ce && powered_down) |=> (!lock_detect && ref_cnt == 14'h0000 && fb_cnt == '0);
  endproperty
  a_pd_lock: assert property (p_pd_lock) else $error("power-down left counters or lock");

  property p_shift;
    @(posedge clk) disable iff (!rst_b)
    (ce && sclk_rise) |=> (shift_reg[0] == $past(data_bit))
      && (shift_reg[`SLS_WORD_W-1:1] == $past(shift_reg[`SLS_WORD_W-2:0]));
  endproperty
  a_shift: assert property (p_shift) else $error("serial shift wrong");

  property p_mute;
    @(posedge clk) disable iff (!rst_b)
    (ce && ctrl_word.mute_until_locked && !lock_detect) |=> !rf_out_enable;
  endproperty
  a_mute: assert property (p_mute) else $error("output on before lock");

  property p_lock_hold;
    @(posedge clk) disable iff (!rst_b)
    (ce && lock_detect && !powered_down && !(pfd_sample && phase_err_above_lose)) |=> lock_detect;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped without large error");

endmodule

//--- core/sls_defs.svh
`ifndef SLS_DEFS_SVH
`define SLS_DEFS_SVH

// Serial word length and the two select bits at the bottom of every word.
`define SLS_WORD_W        24
`define SLS_SEL_CTRL      2'b00
`define SLS_SEL_REF       2'b01
`define SLS_SEL_FBK       2'b10
`define SLS_SEL_TEST      2'b11

// Reset values of the three latches.
`define SLS_CTRL_RESET    24'h000000
`define SLS_FBK_RESET     24'h000000
`define SLS_REF_RESET     24'h000000

// Pin vector positions at the synchroniser.
`define SLS_PIN_W         6
`define SLS_PIN_SCLK      0
`define SLS_PIN_SDATA     1
`define SLS_PIN_STROBE    2
`define SLS_PIN_CE        3
`define SLS_PIN_REF       4
`define SLS_PIN_VCO       5

// Prescaler moduli selected by the two prescaler bits.
`define SLS_PRESC_8       6'h08
`define SLS_PRESC_16      6'h10
`define SLS_PRESC_32      6'h20

// Reference output edges counted before a synchronous power-down.
`define SLS_SYNC_PD_TICKS 2'h2

// Good detector cycles needed to declare lock, fine and coarse precision.
`define SLS_LOCK_FINE     3'h5
`define SLS_LOCK_COARSE   3'h3

// Phase error thresholds in ns, judged by the analog detector outside.
`define SLS_LOCK_SET_NS   15
`define SLS_LOCK_LOSE_NS  25

`endif

//--- core/sls_pin_sync.sv
`include "sls_defs.svh"

// Three-stage synchroniser for asynchronous pins with agreement filter.
module sls_pin_sync #(
  parameter int W = `SLS_PIN_W
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] stage_one;
  logic [W-1:0] stage_two;
  logic [W-1:0] stage_three;
  wire  [W-1:0] agree = ~(stage_two ^ stage_three);
  wire  [W-1:0] next_level = (agree & stage_three) | (~agree & level);

  // The accepted level only moves once the last two stages agree.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stage_one   <= '0;
      stage_two   <= '0;
      stage_three <= '0;
      level       <= '0;
      rise        <= '0;
    end else if (ce) begin
      stage_one   <= pin_in;
      stage_two   <= stage_one;
      stage_three <= stage_two;
      level       <= next_level;
      rise        <= next_level & ~level;
    end
  end

endmodule

//--- core/sls_pkg.sv
package sls_pkg;

  // Control latch layout, most significant bit first.
  typedef struct packed {
    logic [1:0] prescaler_select;
    logic       power_down_mode;
    logic       power_down_arm;
    logic [2:0] pump_current_set_two;
    logic [2:0] pump_current_set_one;
    logic [1:0] output_level;
    logic       mute_until_locked;
    logic       pump_gain_select;
    logic       pump_tristate;
    logic       detector_polarity;
    logic [2:0] monitor_select;
    logic       counter_clear;
    logic [1:0] core_current;
    logic       latch_select_hi;
    logic       latch_select_lo;
  } sls_ctrl_s;

  // Feedback divider latch layout.
  typedef struct packed {
    logic        half_rate_feedback;
    logic        half_rate_output;
    logic        pump_gain_select;
    logic [12:0] main_count;
    logic        spare_bit;
    logic [4:0]  swallow_count;
    logic        latch_select_hi;
    logic        latch_select_lo;
  } sls_fbk_s;

  // Reference divider latch layout.
  typedef struct packed {
    logic [1:0]  reserved;
    logic [1:0]  band_clock_div;
    logic        factory_test_bit;
    logic        lock_precision;
    logic [1:0]  backlash_width;
    logic [13:0] ref_divide_count;
    logic        latch_select_hi;
    logic        latch_select_lo;
  } sls_ref_s;

  // Power-down sequencer states.
  typedef enum logic [1:0] {
    SLS_PD_RUN,
    SLS_PD_WAIT_ONE,
    SLS_PD_WAIT_TWO,
    SLS_PD_DOWN
  } sls_pd_e;

endpackage

//--- sim/sls_core_bench.sv
// Self-checking bench: words go in over the link, outputs are compared.
module sls_core_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic               clk = 1'b0;
  logic               rst_b = 1'b0;
  logic               ce = 1'b1;
  logic               chip_enable_pin = 1'b1;
  logic               ref_pin = 1'b0;
  logic               vco_pin = 1'b0;
  logic               pfd_sample = 1'b0;
  logic               below = 1'b0;
  logic               above = 1'b0;
  wire logic          sclk;
  wire logic          sdata;
  wire logic          latch_strobe;
  sls_pkg::sls_ctrl_s ctrl_word;
  sls_pkg::sls_fbk_s  fbk_word;
  sls_pkg::sls_ref_s  ref_word;
  logic               gain_select;
  logic [2:0]         pump_current;
  logic               pump_tristate_out;
  logic               rf_out_enable;
  logic               ref_buffer_enable;
  logic               output_halved;
  logic               ref_tick;
  logic               fb_tick;
  logic               band_clk_tick;
  logic               lock_detect;
  logic               power_down_out;
  logic               strobe_q = 1'b0;
  int                 strobe_ticks = 0;
  int                 phase = 0;
  int                 failures = 0;
  int                 check_count = 0;
  int                 n;

  always #10 clk = ~clk;

  sls_core sls_core_inst (
    .clk(clk), .rst_b(rst_b), .ce(ce), .sclk(sclk), .sdata(sdata),
    .latch_strobe(latch_strobe), .chip_enable_pin(chip_enable_pin),
    .ref_pin(ref_pin), .vco_pin(vco_pin), .pfd_sample(pfd_sample),
    .phase_err_below_set(below), .phase_err_above_lose(above),
    .ctrl_word(ctrl_word), .fbk_word(fbk_word), .ref_word(ref_word),
    .gain_select(gain_select), .pump_current(pump_current),
    .pump_tristate_out(pump_tristate_out), .rf_out_enable(rf_out_enable),
    .ref_buffer_enable(ref_buffer_enable), .output_halved(output_halved),
    .ref_tick(ref_tick), .fb_tick(fb_tick), .band_clk_tick(band_clk_tick),
    .lock_detect(lock_detect), .power_down_out(power_down_out)
  );

  sls_host_model sls_host_model_inst (
    .clk(clk), .sclk(sclk), .sdata(sdata), .latch_strobe(latch_strobe)
  );

  // Reference and output pins each rise once every eight clocks.
  always @(posedge clk) begin
    phase <= phase + 1;
    if (phase % 4 == 3) begin
      ref_pin <= ~ref_pin;
      vco_pin <= ~vco_pin;
    end
  end

  // Counts reference ticks since the last strobe rise at the pin.
  always @(posedge clk) begin
    strobe_q <= latch_strobe;
    if (latch_strobe && !strobe_q) strobe_ticks <= 0;
    else if (ref_tick === 1'b1) strobe_ticks <= strobe_ticks + 1;
  end

  // Packs the status outputs: gain, tristate, rf, buffer, lock, down.
  function automatic logic [23:0] st();
    return {18'h0, gain_select, pump_tristate_out, rf_out_enable,
            ref_buffer_enable, lock_detect, power_down_out};
  endfunction

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [23:0] w);
    sls_host_model_inst.send_word(w);
    cyc(2);
  endtask

  task automatic pfd(input logic b, input logic a);
    @(posedge clk);
    pfd_sample <= 1'b1;
    below <= b;
    above <= a;
    @(posedge clk);
    pfd_sample <= 1'b0;
    below <= 1'b0;
    above <= 1'b0;
    cyc(3);
  endtask

  // Cycles until the chosen tick is seen, bounded: 0 reference, 1 feedback, 2 band.
  task automatic wait_tick(input logic [1:0] sel, output int k);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while ((((sel == 2'd1) ? fb_tick : (sel == 2'd2) ? band_clk_tick : ref_tick) !== 1'b1)
               && k < 2000);
  endtask

  task automatic wait_strobe_ticks(input int k);
    for (int i = 0; i < 3000 && strobe_ticks < k; i++) cyc(1);
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #800000;
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    chk(24'({ctrl_word, fbk_word, ref_word} == 72'h0), 24'h1);
    chk(st(), 24'h11);
    @(posedge clk);
    rst_b <= 1'b1;
    cyc(8);
    $display("test reset done");
    // Reference count 20, coarse lock, band divide by two.
    wr(24'h120051);
    chk(ref_word, 24'h120051);
    chk(ctrl_word, 24'h0);
    wr(24'h0a8c00);
    chk(ctrl_word, 24'h0a8c00);
    chk(24'(pump_current), 24'h5);
    chk(st(), 24'h24);
    $display("test latch done");
    pfd(1'b1, 1'b0);
    pfd(1'b1, 1'b0);
    chk(24'(lock_detect), 24'h0);
    pfd(1'b1, 1'b0);
    chk(st(), 24'h2e);
    pfd(1'b0, 1'b0);
    chk(24'(lock_detect), 24'h1);
    pfd(1'b0, 1'b1);
    chk(st(), 24'h24);
    $display("test lock done");
    wr(24'hc0037e);
    chk(fbk_word, 24'hc0037e);
    chk(24'(pump_current), 24'h2);
    chk(st(), 24'h04);
    chk(24'(output_halved), 24'h1);
    wr(24'hffffff);
    chk(ctrl_word, 24'h0a8c00);
    chk(fbk_word, 24'hc0037e);
    chk(ref_word, 24'h120051);
    $display("test feedback done");
    wr(24'h160051);
    for (int i = 0; i < 4; i++) pfd(1'b1, 1'b0);
    chk(24'(lock_detect), 24'h0);
    pfd(1'b1, 1'b0);
    chk(st(), 24'h0e);
    wr(24'h1a8c00);
    chk(st(), 24'h31);
    wr(24'h00037e);
    chk(fbk_word, 24'h00037e);
    $display("test async down done");
    wr(24'h0a8400);
    chk(st(), 24'h2c);
    wr(24'h3a8400);
    wait_strobe_ticks(1);
    chk(24'(power_down_out), 24'h0);
    wait_strobe_ticks(2);
    cyc(4);
    chk(st(), 24'h31);
    $display("test sync down done");
    wr(24'h0a8400);
    @(posedge clk);
    chip_enable_pin <= 1'b0;
    cyc(10);
    chk(st(), 24'h31);
    @(posedge clk);
    chip_enable_pin <= 1'b1;
    cyc(10);
    wr(24'h0a8400);
    $display("test chip enable done");
    wait_tick(2'd0, n);
    wait_tick(2'd0, n);
    chk(24'(n), 24'd160);
    wait_tick(2'd1, n);
    wait_tick(2'd1, n);
    chk(24'(n), 24'd440);
    // Band divide by two gives one band tick every second reference tick.
    wait_tick(2'd2, n);
    wait_tick(2'd2, n);
    chk(24'(n), 24'd320);
    // Halved feedback counts every second output edge, so the period doubles.
    wr(24'h80037e);
    wait_tick(2'd1, n);
    wait_tick(2'd1, n);
    chk(24'(n), 24'd880);
    wr(24'h0a8610);
    chk(st(), 24'h3c);
    wait_tick(2'd0, n);
    chk(24'(n), 24'd2000);
    $display("test counters done");
    // With the clock enable low a whole word must pass unseen.
    @(posedge clk);
    ce <= 1'b0;
    wr(24'h120051);
    chk(ref_word, 24'h160051);
    @(posedge clk);
    ce <= 1'b1;
    $display("test clock enable done");
    report_and_stop();
  end
endmodule

//--- sim/sls_host_model.sv
// Host side of the three-wire link: sends whole words, then strobes.
module sls_host_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      sdata,
  output logic      latch_strobe
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle levels at time zero.
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    latch_strobe = 1'b0;
  end

  // Every pin level stands five clocks or more so the synchroniser sees it.
  task automatic send_word(input logic [23:0] word);
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk);
      sdata <= word[i];
      repeat (5) @(posedge clk);
      sclk <= 1'b1;
      repeat (5) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (5) @(posedge clk);
    latch_strobe <= 1'b1;
    repeat (8) @(posedge clk);
    latch_strobe <= 1'b0;
    sdata <= ~word[0]; // The released data line does not keep the last bit.
    repeat (6) @(posedge clk);
  endtask
endmodule
